// [include/alu_status_pkg.sv]
// package: register map, field positions, reset values, carriers
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package alu_status_pkg;

   // register indices (byte address = 4 * index)
   localparam logic [7:0] STATUS_IDX      = 8'h03;
   localparam logic [7:0] OPTION_IDX      = 8'h81;
   localparam logic [7:0] EXEC_IDX        = 8'h40;
   localparam logic [7:0] RESULT_IDX      = 8'h41;
   localparam logic [7:0] EVENT_IDX       = 8'h42;
   localparam logic [7:0] BANK_IDX        = 8'h43;

   // status and option field positions
   localparam int CARRY_BIT    = 0;
   localparam int NIBBLE_BIT   = 1;
   localparam int ZERO_BIT     = 2;
   localparam int PDOWN_BIT    = 3;
   localparam int EXPIRY_BIT   = 4;
   localparam int BANK_LOW_BIT = 5;
   localparam int BANK_HI_BIT  = 6;
   localparam int IND_BIT      = 7;
   localparam int PSA_BIT      = 3;

   // reset values
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam logic [7:0] OPTION_RESET = 8'hff;

   // event register bits
   localparam int EV_WDT_CLEAR = 0;
   localparam int EV_SLEEP     = 1;
   localparam int EV_TIMEOUT   = 2;

   // bank size, bits of in-bank offset
   localparam int BANK_OFFSET_BITS = 7;

   // operation codes written to the execute register
   typedef enum logic [3:0] {
      OP_MOVE   = 4'h0,
      OP_CLEAR  = 4'h1,
      OP_BCLR   = 4'h2,
      OP_BSET   = 4'h3,
      OP_SWAP   = 4'h4,
      OP_ADD    = 4'h5,
      OP_SUB    = 4'h6,
      OP_AND    = 4'h7,
      OP_OR     = 4'h8,
      OP_XOR    = 4'h9
   } alu_op_t;

   typedef struct packed {
      alu_op_t    op;
      logic [2:0] bit_sel;
      logic [7:0] file_val;
      logic [7:0] w_val;
   } alu_cmd_t;

   typedef struct packed {
      logic [7:0] value;
      logic       zero;
      logic       nibble;
      logic       carry;
      logic       z_upd;
      logic       dc_upd;
      logic       c_upd;
   } alu_res_t;

endpackage

// [src/alu_op_unit.sv]
// combinational alu computing result and flag updates
`timescale 1ns/1ps
module alu_op_unit (
   // command in
   input  wire alu_status_pkg::alu_cmd_t cmd_i,
   // result out
   output alu_status_pkg::alu_res_t      res_o
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] rhs;

   always_comb begin
      res_o = '0;
      rhs   = cmd_i.w_val;
      sum   = 9'h000;
      nib   = 5'h00;
      case (cmd_i.op)
         alu_status_pkg::OP_MOVE: begin
            res_o.value = cmd_i.w_val;
         end
         alu_status_pkg::OP_CLEAR: begin
            res_o.value = 8'h00;
            res_o.z_upd = 1'b1;
         end
         alu_status_pkg::OP_BCLR: begin
            res_o.value = cmd_i.file_val & ~(8'h01 << cmd_i.bit_sel);
         end
         alu_status_pkg::OP_BSET: begin
            res_o.value = cmd_i.file_val | (8'h01 << cmd_i.bit_sel);
         end
         alu_status_pkg::OP_SWAP: begin
            res_o.value = {cmd_i.file_val[3:0], cmd_i.file_val[7:4]};
         end
         alu_status_pkg::OP_ADD, alu_status_pkg::OP_SUB: begin
            // subtract adds two's complement: carries are inverse borrows
            if (cmd_i.op == alu_status_pkg::OP_SUB) begin
               rhs = ~cmd_i.w_val;
            end
            sum = {1'b0, cmd_i.file_val} + {1'b0, rhs}
                + {8'h00, cmd_i.op == alu_status_pkg::OP_SUB};
            nib = {1'b0, cmd_i.file_val[3:0]} + {1'b0, rhs[3:0]}
                + {4'h0, cmd_i.op == alu_status_pkg::OP_SUB};
            res_o.value  = sum[7:0];
            res_o.carry  = sum[8];
            res_o.nibble = nib[4];
            res_o.z_upd  = 1'b1;
            res_o.dc_upd = 1'b1;
            res_o.c_upd  = 1'b1;
         end
         alu_status_pkg::OP_AND: begin
            res_o.value = cmd_i.file_val & cmd_i.w_val;
            res_o.z_upd = 1'b1;
         end
         alu_status_pkg::OP_OR: begin
            res_o.value = cmd_i.file_val | cmd_i.w_val;
            res_o.z_upd = 1'b1;
         end
         alu_status_pkg::OP_XOR: begin
            res_o.value = cmd_i.file_val ^ cmd_i.w_val;
            res_o.z_upd = 1'b1;
         end
         default: begin
            res_o.value = cmd_i.file_val;
         end
      endcase
      res_o.zero = (res_o.value == 8'h00);
   end
endmodule

// [src/alu_status_bank.sv]
// status register bank with alu execute port over axi4-lite
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module alu_status_bank (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // axi4-lite write address
   input  wire logic [9:0]  s_awaddr_i,
   input  wire logic        s_awvalid_i,
   output logic             s_awready_o,
   // axi4-lite write data
   input  wire logic [31:0] s_wdata_i,
   input  wire logic [3:0]  s_wstrb_i,
   input  wire logic        s_wvalid_i,
   output logic             s_wready_o,
   // axi4-lite write response
   output logic [1:0]       s_bresp_o,
   output logic             s_bvalid_o,
   input  wire logic        s_bready_i,
   // axi4-lite read address
   input  wire logic [9:0]  s_araddr_i,
   input  wire logic        s_arvalid_i,
   output logic             s_arready_o,
   // axi4-lite read data
   output logic [31:0]      s_rdata_o,
   output logic [1:0]       s_rresp_o,
   output logic             s_rvalid_o,
   input  wire logic        s_rready_i,
   // bank selection and prescaler assignment outputs
   output logic [1:0]       direct_bank_o,
   output logic             indirect_bank_o,
   output logic             prescale_to_wdt_o
);
   localparam logic [1:0] RESP_OK  = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0]  status, next_status;
   logic [7:0]  option, next_option;
   logic [7:0]  result, next_result;
   logic        aw_held, next_aw_held;
   logic        w_held, next_w_held;
   logic [7:0]  aw_idx, next_aw_idx;
   logic [31:0] wdata, next_wdata;
   logic [3:0]  wstrb, next_wstrb;
   logic        bvalid, next_bvalid;
   logic [1:0]  bresp, next_bresp;
   logic        rvalid, next_rvalid;
   logic [1:0]  rresp, next_rresp;
   logic [31:0] rdata, next_rdata;

   alu_status_pkg::alu_cmd_t cmd;
   alu_status_pkg::alu_res_t res;

   function automatic logic [7:0] word_idx(input logic [9:0] addr);
      return addr[9:2];
   endfunction

   alu_op_unit u_alu (
      .cmd_i (cmd),
      .res_o (res)
   );

   // ---------------------------------------------------------------
   // write channel and register update
   // ---------------------------------------------------------------
   logic do_write;
   logic dest_status;
   logic [7:0] sel_file;
   logic [7:0] wr_merged;

   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_idx  = aw_idx;
      next_wdata   = wdata;
      next_wstrb   = wstrb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_status  = status;
      next_option  = option;
      next_result  = result;
      dest_status  = 1'b0;
      sel_file     = 8'h00;
      wr_merged    = 8'h00;
      cmd          = '0;
      if (s_awvalid_i && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_idx  = word_idx(s_awaddr_i);
      end
      if (s_wvalid_i && !w_held) begin
         next_w_held = 1'b1;
         next_wdata  = s_wdata_i;
         next_wstrb  = s_wstrb_i;
      end
      do_write = aw_held && w_held && !bvalid;
      // exec word: [7:0] w, [15:8] file value, [18:16] bit, [23:20] op,
      // [24] destination is status
      dest_status = wdata[24];
      sel_file    = dest_status ? status : wdata[15:8];
      cmd.op       = alu_status_pkg::alu_op_t'(wdata[23:20]);
      cmd.bit_sel  = wdata[18:16];
      cmd.file_val = sel_file;
      cmd.w_val    = wdata[7:0];
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = RESP_OK;
         if (aw_idx == alu_status_pkg::STATUS_IDX) begin
            // plain store: reset-cause bits are read-only
            if (wstrb[0]) begin
               wr_merged = wdata[7:0];
               wr_merged[alu_status_pkg::EXPIRY_BIT] =
                  status[alu_status_pkg::EXPIRY_BIT];
               wr_merged[alu_status_pkg::PDOWN_BIT] =
                  status[alu_status_pkg::PDOWN_BIT];
               next_status = wr_merged;
            end
         end else if (aw_idx == alu_status_pkg::OPTION_IDX) begin
            if (wstrb[0]) begin
               next_option = wdata[7:0];
            end
         end else if (aw_idx == alu_status_pkg::EXEC_IDX) begin
            if (wstrb[0] && wstrb[1] && wstrb[2] && wstrb[3]) begin
               next_result = res.value;
               if (dest_status) begin
                  wr_merged = res.value;
                  wr_merged[alu_status_pkg::EXPIRY_BIT] =
                     status[alu_status_pkg::EXPIRY_BIT];
                  wr_merged[alu_status_pkg::PDOWN_BIT] =
                     status[alu_status_pkg::PDOWN_BIT];
                  // any flag touched: data write to all three blocked
                  if (res.z_upd || res.dc_upd || res.c_upd) begin
                     wr_merged[2:0] = status[2:0];
                  end
                  // flags the op touches come from the result
                  if (res.z_upd) begin
                     wr_merged[alu_status_pkg::ZERO_BIT] = res.zero;
                  end
                  if (res.dc_upd) begin
                     wr_merged[alu_status_pkg::NIBBLE_BIT] = res.nibble;
                  end
                  if (res.c_upd) begin
                     wr_merged[alu_status_pkg::CARRY_BIT] = res.carry;
                  end
                  next_status = wr_merged;
               end else begin
                  if (res.z_upd) begin
                     next_status[alu_status_pkg::ZERO_BIT] = res.zero;
                  end
                  if (res.dc_upd) begin
                     next_status[alu_status_pkg::NIBBLE_BIT] = res.nibble;
                  end
                  if (res.c_upd) begin
                     next_status[alu_status_pkg::CARRY_BIT] = res.carry;
                  end
               end
            end
         end else if (aw_idx == alu_status_pkg::EVENT_IDX) begin
            if (wstrb[0]) begin
               if (wdata[alu_status_pkg::EV_TIMEOUT]) begin
                  next_status[alu_status_pkg::EXPIRY_BIT] = 1'b0;
               end else if (wdata[alu_status_pkg::EV_SLEEP]) begin
                  next_status[alu_status_pkg::EXPIRY_BIT] = 1'b1;
                  next_status[alu_status_pkg::PDOWN_BIT]  = 1'b0;
               end else if (wdata[alu_status_pkg::EV_WDT_CLEAR]) begin
                  next_status[alu_status_pkg::EXPIRY_BIT] = 1'b1;
                  next_status[alu_status_pkg::PDOWN_BIT]  = 1'b1;
               end
            end
         end else begin
            next_bresp = RESP_ERR;
         end
      end
      if (bvalid && s_bready_i) begin
         next_bvalid = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   always_comb begin
      next_rvalid = rvalid;
      next_rresp  = rresp;
      next_rdata  = rdata;
      if (rvalid && s_rready_i) begin
         next_rvalid = 1'b0;
      end
      if (s_arvalid_i && !rvalid) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OK;
         next_rdata  = 32'h0000_0000;
         if (word_idx(s_araddr_i) == alu_status_pkg::STATUS_IDX) begin
            next_rdata[7:0] = status;
         end else if (word_idx(s_araddr_i) == alu_status_pkg::OPTION_IDX)
         begin
            next_rdata[7:0] = option;
         end else if (word_idx(s_araddr_i) == alu_status_pkg::RESULT_IDX)
         begin
            next_rdata[7:0] = result;
         end else if (word_idx(s_araddr_i) == alu_status_pkg::BANK_IDX)
         begin
            next_rdata[2:0] = {status[alu_status_pkg::IND_BIT],
                               status[alu_status_pkg::BANK_HI_BIT],
                               status[alu_status_pkg::BANK_LOW_BIT]};
         end else if (word_idx(s_araddr_i) != alu_status_pkg::EXEC_IDX &&
                      word_idx(s_araddr_i) != alu_status_pkg::EVENT_IDX)
         begin
            next_rresp = RESP_ERR;
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         status  <= alu_status_pkg::STATUS_RESET;
         option  <= alu_status_pkg::OPTION_RESET;
         result  <= 8'h00;
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_idx  <= 8'h00;
         wdata   <= 32'h0000_0000;
         wstrb   <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= 2'b00;
         rvalid  <= 1'b0;
         rresp   <= 2'b00;
         rdata   <= 32'h0000_0000;
      end else begin
         status  <= next_status;
         option  <= next_option;
         result  <= next_result;
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         aw_idx  <= next_aw_idx;
         wdata   <= next_wdata;
         wstrb   <= next_wstrb;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         rvalid  <= next_rvalid;
         rresp   <= next_rresp;
         rdata   <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   logic [1:0] bank_q;
   logic       ind_q;
   logic       psa_q;
   logic       awr_q;
   logic       wr_q;
   logic       arr_q;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bank_q <= 2'b00;
         ind_q  <= 1'b0;
         psa_q  <= 1'b1;
         awr_q  <= 1'b0;
         wr_q   <= 1'b0;
         arr_q  <= 1'b0;
      end else begin
         bank_q <= {next_status[alu_status_pkg::BANK_HI_BIT],
                    next_status[alu_status_pkg::BANK_LOW_BIT]};
         ind_q  <= next_status[alu_status_pkg::IND_BIT];
         psa_q  <= next_option[alu_status_pkg::PSA_BIT];
         awr_q  <= !next_aw_held;
         wr_q   <= !next_w_held;
         arr_q  <= !next_rvalid;
      end
   end

   assign direct_bank_o     = bank_q;
   assign indirect_bank_o   = ind_q;
   assign prescale_to_wdt_o = psa_q;
   assign s_awready_o       = awr_q;
   assign s_wready_o        = wr_q;
   assign s_arready_o       = arr_q;
   assign s_bvalid_o        = bvalid;
   assign s_bresp_o         = bresp;
   assign s_rvalid_o        = rvalid;
   assign s_rresp_o         = rresp;
   assign s_rdata_o         = rdata;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_bank_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      direct_bank_o == status[6:5])
      else $error("direct bank output does not follow status");
   a_ind_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      indirect_bank_o == status[7])
      else $error("indirect bank output does not follow status");
   a_cause_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (do_write && aw_idx != alu_status_pkg::EVENT_IDX)
      |=> status[4:3] == $past(status[4:3]))
      else $error("reset cause bits written by software");
   a_timeout_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (do_write && aw_idx == alu_status_pkg::EVENT_IDX && wstrb[0]
       && wdata[2]) |=> !status[4])
      else $error("expiry flag not cleared on time-out");
   a_sleep_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (do_write && aw_idx == alu_status_pkg::EVENT_IDX && wstrb[0]
       && !wdata[2] && wdata[1]) |=> status[4:3] == 2'b10)
      else $error("sleep did not set expiry and clear power-down");
   a_wdt_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (do_write && aw_idx == alu_status_pkg::EVENT_IDX && wstrb[0]
       && wdata[2:0] == 3'b001) |=> status[4:3] == 2'b11)
      else $error("watchdog clear did not set both cause bits");
   a_clear_status: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (do_write && aw_idx == alu_status_pkg::EXEC_IDX && &wstrb
       && wdata[24] && wdata[23:20] == 4'h1)
      |=> status[7:5] == 3'b000 && status[2]
          && status[4:3] == $past(status[4:3])
          && status[1:0] == $past(status[1:0]))
      else $error("clear of status gave wrong pattern");
   a_zero_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (do_write && aw_idx == alu_status_pkg::EXEC_IDX && &wstrb
       && res.z_upd) |=> status[2] == (result == 8'h00))
      else $error("zero flag disagrees with result");
   a_sub_borrow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (do_write && aw_idx == alu_status_pkg::EXEC_IDX && &wstrb
       && wdata[23:20] == 4'h6)
      |=> status[0] == ($past(sel_file) >= $past(wdata[7:0])))
      else $error("subtract carry is not inverse borrow");
   a_resp_after: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      do_write |=> s_bvalid_o)
      else $error("write response missing");
endmodule

// [dv/alu_status_bank_test.sv]
// self-checking bench for the status register bank
`timescale 1ns/1ps
module alu_status_bank_test;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [9:0]  s_awaddr_i = 10'h000;
   logic        s_awvalid_i = 1'b0;
   logic        s_awready_o;
   logic [31:0] s_wdata_i = 32'h0;
   logic [3:0]  s_wstrb_i = 4'hf;
   logic        s_wvalid_i = 1'b0;
   logic        s_wready_o;
   logic [1:0]  s_bresp_o;
   logic        s_bvalid_o;
   logic        s_bready_i = 1'b0;
   logic [9:0]  s_araddr_i = 10'h000;
   logic        s_arvalid_i = 1'b0;
   logic        s_arready_o;
   logic [31:0] s_rdata_o;
   logic [1:0]  s_rresp_o;
   logic        s_rvalid_o;
   logic        s_rready_i = 1'b0;
   logic [1:0]  direct_bank_o;
   logic        indirect_bank_o;
   logic        prescale_to_wdt_o;
   int          err_total = 0;
   int          n_compared = 0;
   logic [1:0]  bq[$];
   logic [33:0] rq[$];
   logic [7:0]  st;
   logic [10:0] ex;
   logic [2:0]  bs = 3'h0;
   logic [7:0]  f;
   logic [7:0]  w;

   localparam logic [9:0] A_ST  = 10'h00c;
   localparam logic [9:0] A_OPT = 10'h204;
   localparam logic [9:0] A_EX  = 10'h100;
   localparam logic [9:0] A_RES = 10'h104;
   localparam logic [9:0] A_EV  = 10'h108;
   localparam logic [9:0] A_BAD = 10'h3fc;

   always #20 clk_i = ~clk_i;

   alu_status_bank i_dut (.*);

   // ---------------------------------------------------------------
   // bus tasks and checks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      bq.push_back(r);
      s_awaddr_i <= a;
      s_wdata_i <= d;
      s_awvalid_i <= 1'b1;
      s_wvalid_i <= 1'b1;
      s_bready_i <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (!aw_done && s_awready_o) begin
            s_awvalid_i <= 1'b0;
            aw_done = 1'b1;
         end
         if (!w_done && s_wready_o) begin
            s_wvalid_i <= 1'b0;
            w_done = 1'b1;
         end
         if (s_bvalid_o) begin
            s_bready_i <= 1'b0;
            break;
         end
      end
      // let the release settle before the next request
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [9:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      logic ar_done;
      ar_done = 1'b0;
      rq.push_back({r, d});
      s_araddr_i <= a;
      s_arvalid_i <= 1'b1;
      s_rready_i <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (!ar_done && s_arready_o) begin
            s_arvalid_i <= 1'b0;
            ar_done = 1'b1;
         end
         if (s_rvalid_o) begin
            s_rready_i <= 1'b0;
            break;
         end
      end
      // let the release settle before the next request
      @(posedge clk_i);
   endtask

   // response watcher: oldest note against each answer
   always @(posedge clk_i) begin
      logic [33:0] e;
      if (s_bvalid_o && s_bready_i) begin
         chk({30'h0, s_bresp_o}, {30'h0, bq.pop_front()});
      end
      if (s_rvalid_o && s_rready_i) begin
         e = rq.pop_front();
         chk({30'h0, s_rresp_o}, {30'h0, e[33:32]});
         if (e[33:32] === 2'b00) begin
            chk(s_rdata_o, e[31:0]);
         end
      end
   end

   // expected {value, zero, nibble, carry}
   function automatic logic [10:0] model(input logic [3:0] op,
                                         input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [2:0] k);
      logic [8:0] s;
      logic [4:0] n;
      s = 9'h0;
      n = 5'h0;
      case (op)
         4'h0: s = {1'b0, b};
         4'h2: s = {1'b0, a & ~(8'h01 << k)};
         4'h3: s = {1'b0, a | (8'h01 << k)};
         4'h4: s = {1'b0, a[3:0], a[7:4]};
         4'h5: begin
            s = {1'b0, a} + {1'b0, b};
            n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
         end
         4'h6: begin
            s = {1'b0, a} + {1'b0, ~b} + 9'h001;
            n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
         end
         4'h7: s = {1'b0, a & b};
         4'h8: s = {1'b0, a | b};
         default: s = {1'b0, a ^ b};
      endcase
      return {s[7:0], s[7:0] == 8'h00, n[4], s[8]};
   endfunction

   task automatic exec_op(input logic [3:0] op, input logic dst);
      logic [7:0] src;
      src = dst ? st : f;
      ex = model(op, src, w, bs);
      wr(A_EX, {7'h0, dst, op, 1'b0, bs, f, w}, 2'b00);
      if (op == 4'h5 || op == 4'h6) begin
         st[1:0] = ex[1:0];
      end
      if (op >= 4'h5) begin
         st[2] = ex[2];
      end
      if (dst && op >= 4'h5) begin
         st = {ex[10:8], st[4:0]};
      end else if (dst) begin
         st = {ex[10:8], st[4:3], ex[5:3]};
      end
      rd(A_RES, {24'h0, ex[10:3]}, 2'b00);
      rd(A_ST, {24'h0, st}, 2'b00);
   endtask

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      print_verdict();
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h9ce18518));
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      st = 8'h18;
      rd(A_ST, 32'h18, 2'b00);
      rd(A_OPT, 32'hff, 2'b00);
      chk({29'h0, direct_bank_o, indirect_bank_o}, 32'h0);
      chk({31'h0, prescale_to_wdt_o}, 32'h1);
      $display("reset values done");
      for (int b = 0; b < 4; b++) begin
         wr(A_ST, {24'h0, b[0], b[1:0], 5'h00}, 2'b00);
         st = {b[0], b[1:0], st[4:0]};
         chk({30'h0, direct_bank_o}, {30'h0, b[1:0]});
         chk({31'h0, indirect_bank_o}, {31'h0, b[0]});
         rd(A_ST, {24'h0, st}, 2'b00);
      end
      $display("bank select done");
      for (int e = 0; e < 3; e++) begin
         wr(A_EV, 32'h1 << e, 2'b00);
         if (e == 0) st[4:3] = 2'b11;
         if (e == 1) st[4:3] = 2'b10;
         if (e == 2) st[4] = 1'b0;
         rd(A_ST, {24'h0, st}, 2'b00);
         wr(A_ST, {24'h0, ~st}, 2'b00);
         st = {~st[7:5], st[4:3], ~st[2:0]};
         rd(A_ST, {24'h0, st}, 2'b00);
      end
      $display("event flags done");
      wr(A_ST, 32'he1, 2'b00);
      st = {3'b111, st[4:3], 3'b001};
      wr(A_EX, {7'h0, 1'b1, 4'h1, 12'h0, 8'h00}, 2'b00);
      st = {3'b000, st[4:3], 1'b1, st[1:0]};
      rd(A_ST, {24'h0, st}, 2'b00);
      $display("clear on status done");
      for (int i = 0; i < 16; i++) begin
         f = 8'($urandom());
         w = (i == 4) ? f : 8'($urandom());
         if (i == 5) w = 8'h0f;
         exec_op(4'h5 + 4'(i % 5), 1'b0);
      end
      f = 8'h00;
      w = 8'h01;
      exec_op(4'h6, 1'b0);
      w = 8'($urandom());
      exec_op(4'h5, 1'b1);
      for (int i = 0; i < 4; i++) begin
         bs = 3'($urandom());
         w = 8'($urandom());
         exec_op((i == 0) ? 4'h0 : 4'(i + 1), 1'b1);
      end
      $display("alu flags done");
      wr(A_OPT, 32'h00, 2'b00);
      chk({31'h0, prescale_to_wdt_o}, 32'h0);
      rd(A_OPT, 32'h00, 2'b00);
      wr(A_OPT, 32'h08, 2'b00);
      chk({31'h0, prescale_to_wdt_o}, 32'h1);
      rd(A_OPT, 32'h08, 2'b00);
      $display("option register done");
      rd(A_BAD, 32'h0, 2'b10);
      wr(A_BAD, 32'h5a, 2'b10);
      rd(A_ST, {24'h0, st}, 2'b00);
      $display("unmapped access done");
      repeat (3) @(posedge clk_i);
      print_verdict();
   end
endmodule
